//--- design/uart_rx_pkg.sv
// Shared constants and types for the receive error, interrupt and wake-up block.
package uart_rx_pkg;

  // Register byte offsets on the Avalon-MM bus.
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] CTRL2_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS = 8'h0c;
  localparam logic [7:0] BAUD_OFS = 8'h10;

  // Status register bit positions.
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_TX_IDLE = 1;
  localparam int ST_RX_AVAIL = 2;
  localparam int ST_RX_IDLE = 3;
  localparam int ST_FRAMING = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_NOISE = 6;
  localparam int ST_PARITY = 7;

  // Control register one bit positions.
  localparam int C1_RX_BIT8 = 0;
  localparam int C1_TWO_STOP = 3;
  localparam int C1_PARITY_ODD = 4;
  localparam int C1_PARITY_EN = 5;
  localparam int C1_NINE_BIT = 6;
  localparam int C1_UART_EN = 7;

  // Control register two bit positions.
  localparam int C2_TX_EMPTY_IE = 1;
  localparam int C2_TX_IDLE_IE = 2;
  localparam int C2_RX_IE = 3;
  localparam int C2_RESUME_EN = 4;
  localparam int C2_ADDR_EN = 5;
  localparam int C2_RX_EN = 7;

  // Reset values of the writable registers.
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // Oversampling: sixteen sub-ticks per bit, majority of three mid samples.
  localparam logic [3:0] OS_SAMPLE_A = 4'h7;
  localparam logic [3:0] OS_SAMPLE_B = 4'h8;
  localparam logic [3:0] OS_DECIDE = 4'h9;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  // Post-wake recovery interval, a least time rounded up to whole cycles.
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_RECOVERY_NS = 1000;
  localparam logic [7:0] WAKE_RECOVERY_CYCLES =
    8'((WAKE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  // One received word with the error flags that travel with it.
  typedef struct packed {
    logic ninth;
    logic framing;
    logic parity;
    logic noise;
    logic [7:0] data;
  } rx_word_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP1,
    RX_STOP2
  } rx_phase_t;

  typedef struct packed {
    rx_word_t slot0;
    rx_word_t slot1;
    logic [1:0] count;
  } fifo_state_t;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] baud;
    avmm_rsp_t rsp;
    logic read_had_word;
    logic irq_n;
    logic wake_req;
    rx_phase_t phase;
    logic [7:0] baud_cnt;
    logic [3:0] os_cnt;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic par_acc;
    logic samp_a;
    logic samp_b;
    logic noise_acc;
    logic stop_bad;
    logic overrun;
    logic status_armed;
    logic rx_prev;
    logic tx_empty_prev;
    logic tx_idle_prev;
    logic stopped_prev;
    logic wake_pending;
    logic [7:0] recov_cnt;
  } core_state_t;

endpackage

//--- design/rx_word_buffer.sv
// Two-entry receive word buffer with a registered head entry.
`timescale 1ns/1ps
`default_nettype none
module rx_word_buffer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic pop,
  input wire uart_rx_pkg::rx_word_t wr_word,
  output uart_rx_pkg::rx_word_t head,
  output logic [1:0] count
);
  import uart_rx_pkg::*;

  fifo_state_t s_q;
  fifo_state_t s_d;

  // The caller never pushes into a full buffer; a pop on empty is ignored.
  always_comb begin
    s_d = s_q;
    if (pop && s_q.count != 2'd0) begin
      s_d.slot0 = s_q.slot1;
      s_d.count = s_q.count - 2'd1;
    end
    if (push) begin
      if (s_d.count == 2'd0) begin
        s_d.slot0 = wr_word;
      end else begin
        s_d.slot1 = wr_word;
      end
      s_d.count = s_d.count + 2'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign head = s_q.slot0;
  assign count = s_q.count;

endmodule
`default_nettype wire

//--- design/uart_rx_error_irq_wake.sv
// Receiver, error flags, interrupt pulse and line wake-up of the serial port.
//
// Overview of operation
// - Two words buffered while third shifts in.
// - Overrun sets flag, keeps buffer, may interrupt.
// - Overrun clears by status read, data read.
// - Noise flag rises with available flag, no interrupt.
// - Noise clears by status read, data read.
// - Zero in any stop bit sets framing.
// - Framing stored with word, cleared by reset.
// - Parity error only when parity enabled, stored.
// - Interrupt is one low pulse, five sources.
// - Enables mask sources; receive pair shares one.
// - Address mode interrupts only on top bit one.
// - Without address mode every word interrupts.
// - Falling line edge while stopped requests wake-up.
// - Line data during recovery is discarded.
// - Wake interrupt needs both global enables.
// - Wake interrupt waits for recovery interval end.
// - Stopped clock freezes transfer, then resumes.
// - Stop instruction leaves all registers unchanged.
// - Status flags read-only, cleared by sequences or reset.
// - Nine-bit mode keeps top bit separately.
// - Available flag clears by status, data read.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_error_irq_wake (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire uart_rx_pkg::avmm_req_t bus_req,
  output uart_rx_pkg::avmm_rsp_t bus_rsp,
  input wire logic rx_pin,
  input wire logic tx_empty_flag,
  input wire logic tx_idle_flag,
  input wire logic source_clock_stopped,
  input wire logic stop_instruction,
  input wire logic global_irq_enable,
  input wire logic uart_irq_enable,
  output logic irq_n,
  output logic wake_req
);
  import uart_rx_pkg::*;

  core_state_t s_q;
  core_state_t s_d;
  rx_word_t head;
  rx_word_t new_word;
  logic [1:0] fifo_count;
  logic fifo_empty;
  logic fifo_full;
  logic push;
  logic pop;
  logic overrun_evt;
  logic rx_irq_evt;
  logic wake_fire;
  logic accept;
  logic bit_val;
  logic bit_noisy;
  logic rx_on;
  logic frame_done;
  logic wake_armed;
  logic [7:0] status_val;
  logic [3:0] nbits;

  assign fifo_empty = (fifo_count == 2'd0);
  assign fifo_full = (fifo_count == 2'd2);

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer.

  rx_word_buffer u_buffer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .push(push),
    .pop(pop),
    .wr_word(new_word),
    .head(head),
    .count(fifo_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block.

  // The stop instruction itself touches no register; only the clock-stop input freezes logic.
  always_comb begin
    s_d = s_q;
    push = 1'b0;
    pop = 1'b0;
    overrun_evt = 1'b0;
    rx_irq_evt = 1'b0;
    wake_fire = 1'b0;
    frame_done = 1'b0;
    new_word = '0;
    bit_val = 1'b0;
    bit_noisy = 1'b0;
    nbits = s_q.ctrl1[C1_NINE_BIT] ? BITS_NINE : BITS_EIGHT;
    rx_on = s_q.ctrl1[C1_UART_EN] && s_q.ctrl2[C2_RX_EN];
    accept = (bus_req.read || bus_req.write) && !s_q.rsp.waitrequest;
    wake_armed = s_q.ctrl2[C2_RESUME_EN] && s_q.ctrl1[C1_UART_EN] && s_q.ctrl2[C2_RX_EN] &&
                 s_q.ctrl2[C2_RX_IE];
    status_val = '0;
    status_val[ST_TX_EMPTY] = tx_empty_flag;
    status_val[ST_TX_IDLE] = tx_idle_flag;
    status_val[ST_RX_AVAIL] = !fifo_empty;
    status_val[ST_RX_IDLE] = (s_q.phase == RX_IDLE);
    status_val[ST_FRAMING] = !fifo_empty && head.framing;
    status_val[ST_OVERRUN] = s_q.overrun;
    status_val[ST_NOISE] = !fifo_empty && head.noise;
    status_val[ST_PARITY] = !fifo_empty && head.parity;

    // Bus slave: one wait cycle, read data prepared while waitrequest is high.
    s_d.rsp.waitrequest = 1'b1;
    if ((bus_req.read || bus_req.write) && s_q.rsp.waitrequest) begin
      s_d.rsp.waitrequest = 1'b0;
      s_d.read_had_word = !fifo_empty;
      s_d.rsp.readdata = '0;
      if (bus_req.address == STATUS_OFS) begin
        s_d.rsp.readdata[7:0] = status_val;
      end else if (bus_req.address == CTRL1_OFS) begin
        s_d.rsp.readdata[7:0] = {s_q.ctrl1[7:1], head.ninth};
      end else if (bus_req.address == CTRL2_OFS) begin
        s_d.rsp.readdata[7:0] = s_q.ctrl2;
      end else if (bus_req.address == DATA_OFS) begin
        s_d.rsp.readdata[7:0] = head.data;
      end else if (bus_req.address == BAUD_OFS) begin
        s_d.rsp.readdata[7:0] = s_q.baud;
      end
    end

    // Side effects take place on the edge that completes the transfer.
    if (accept && bus_req.write) begin
      if (bus_req.address == CTRL1_OFS) begin
        s_d.ctrl1 = {bus_req.writedata[7:1], 1'b0};
      end else if (bus_req.address == CTRL2_OFS) begin
        s_d.ctrl2 = bus_req.writedata[7:0];
      end else if (bus_req.address == BAUD_OFS) begin
        s_d.baud = bus_req.writedata[7:0];
      end
    end
    if (accept && bus_req.read) begin
      if (bus_req.address == STATUS_OFS) begin
        s_d.status_armed = 1'b1;
      end else if (bus_req.address == DATA_OFS && s_q.status_armed) begin
        // A plain data read without the status access clears nothing.
        s_d.status_armed = 1'b0;
        s_d.overrun = 1'b0;
        pop = s_q.read_had_word;
      end
    end

    // Receiver; frozen while the source clock is stopped, unless recovering from a wake.
    if (s_q.recov_cnt != 8'd0) begin
      s_d.phase = RX_IDLE;
      s_d.recov_cnt = s_q.recov_cnt - 8'd1;
      if (s_q.recov_cnt == 8'd1 && s_q.wake_pending) begin
        s_d.wake_pending = 1'b0;
        wake_fire = global_irq_enable && uart_irq_enable;
      end
    end else if (source_clock_stopped) begin
      s_d.phase = s_q.phase;
    end else if (!rx_on) begin
      s_d.phase = RX_IDLE;
      s_d.baud_cnt = '0;
    end else if (s_q.baud_cnt != s_q.baud) begin
      s_d.baud_cnt = s_q.baud_cnt + 8'd1;
    end else begin
      s_d.baud_cnt = '0;
      bit_val = (s_q.samp_a && s_q.samp_b) || (s_q.samp_a && rx_pin) || (s_q.samp_b && rx_pin);
      bit_noisy = !(s_q.samp_a == s_q.samp_b && s_q.samp_b == rx_pin);
      if (s_q.phase == RX_IDLE) begin
        if (!rx_pin) begin
          s_d.phase = RX_START;
          s_d.os_cnt = 4'h1;
          s_d.bit_cnt = '0;
          s_d.noise_acc = 1'b0;
          s_d.stop_bad = 1'b0;
          s_d.par_acc = 1'b0;
        end
      end else begin
        s_d.os_cnt = s_q.os_cnt + 4'h1;
        if (s_q.os_cnt == OS_SAMPLE_A) begin
          s_d.samp_a = rx_pin;
        end
        if (s_q.os_cnt == OS_SAMPLE_B) begin
          s_d.samp_b = rx_pin;
        end
        if (s_q.os_cnt == OS_DECIDE) begin
          s_d.noise_acc = s_q.noise_acc || bit_noisy;
          case (s_q.phase)
            RX_START: begin
              if (bit_val) begin
                s_d.phase = RX_IDLE;
              end
            end
            RX_DATA: begin
              s_d.shift = {bit_val, s_q.shift[8:1]};
              s_d.par_acc = s_q.par_acc ^ bit_val;
            end
            RX_PARITY: begin
              s_d.par_acc = s_q.par_acc ^ bit_val;
            end
            RX_STOP1: begin
              s_d.stop_bad = !bit_val;
              frame_done = !s_q.ctrl1[C1_TWO_STOP];
            end
            RX_STOP2: begin
              s_d.stop_bad = s_q.stop_bad || !bit_val;
              frame_done = 1'b1;
            end
            default: begin
              s_d.phase = RX_IDLE;
            end
          endcase
        end
        if (s_q.os_cnt == OS_LAST) begin
          case (s_q.phase)
            RX_START: begin
              s_d.phase = RX_DATA;
            end
            RX_DATA: begin
              s_d.bit_cnt = s_q.bit_cnt + 4'h1;
              if (s_q.bit_cnt == nbits - 4'h1) begin
                s_d.phase = s_q.ctrl1[C1_PARITY_EN] ? RX_PARITY : RX_STOP1;
              end
            end
            RX_PARITY: begin
              s_d.phase = RX_STOP1;
            end
            RX_STOP1: begin
              s_d.phase = RX_STOP2;
            end
            default: begin
              s_d.phase = RX_IDLE;
            end
          endcase
        end
      end
    end

    // Word completion: the top received bit sits in shift[8] for both lengths.
    if (frame_done) begin
      s_d.phase = RX_IDLE;
      new_word.ninth = s_q.ctrl1[C1_NINE_BIT] && s_q.shift[8];
      new_word.data = s_q.ctrl1[C1_NINE_BIT] ? s_q.shift[7:0] : s_q.shift[8:1];
      new_word.framing = s_d.stop_bad;
      new_word.parity = s_q.ctrl1[C1_PARITY_EN] && (s_q.par_acc != s_q.ctrl1[C1_PARITY_ODD]);
      new_word.noise = s_d.noise_acc;
      if (fifo_full) begin
        overrun_evt = 1'b1;
      end else begin
        push = 1'b1;
        rx_irq_evt = s_q.ctrl2[C2_RX_IE] &&
                     (!s_q.ctrl2[C2_ADDR_EN] || s_q.shift[8]);
      end
    end
    // A new overrun wins over a clearing read in the same cycle.
    if (overrun_evt) begin
      s_d.overrun = 1'b1;
    end

    // Line-pin wake-up while the source clock is stopped.
    s_d.rx_prev = rx_pin;
    s_d.stopped_prev = source_clock_stopped;
    s_d.wake_req = 1'b0;
    if (source_clock_stopped && wake_armed && s_q.rx_prev && !rx_pin) begin
      s_d.wake_req = 1'b1;
      s_d.wake_pending = 1'b1;
    end
    if (s_q.stopped_prev && !source_clock_stopped && s_q.wake_pending) begin
      s_d.recov_cnt = WAKE_RECOVERY_CYCLES;
    end

    // Interrupt: one low pulse for any enabled source.
    s_d.tx_empty_prev = tx_empty_flag;
    s_d.tx_idle_prev = tx_idle_flag;
    s_d.irq_n = !(rx_irq_evt ||
                  (overrun_evt && s_q.ctrl2[C2_RX_IE]) ||
                  (tx_empty_flag && !s_q.tx_empty_prev && s_q.ctrl2[C2_TX_EMPTY_IE]) ||
                  (tx_idle_flag && !s_q.tx_idle_prev && s_q.ctrl2[C2_TX_IDLE_IE]) ||
                  wake_fire);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.ctrl1 <= CTRL1_RST;
      s_q.ctrl2 <= CTRL2_RST;
      s_q.baud <= BAUD_RST;
      s_q.rsp.waitrequest <= 1'b1;
      s_q.irq_n <= 1'b1;
      s_q.rx_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rsp = s_q.rsp;
  assign irq_n = s_q.irq_n;
  assign wake_req = s_q.wake_req;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence seq_status_read;
    accept && bus_req.read && bus_req.address == STATUS_OFS;
  endsequence

  sequence seq_data_read;
    accept && bus_req.read && bus_req.address == DATA_OFS;
  endsequence

  chk_overrun_keeps_buffer: assert property (overrun_evt |=> s_q.overrun && fifo_count == 2'd2)
    else $error("Overrun did not set flag or lost buffered words.");
  chk_overrun_clear_order: assert property (seq_status_read ##1 (!accept) [*2] ##1
    (seq_data_read and !overrun_evt) |=> !s_q.overrun)
    else $error("Overrun flag survived the clear sequence.");
  chk_overrun_no_plain_clear: assert property ($fell(s_q.overrun) |->
    $past(accept && bus_req.read && bus_req.address == DATA_OFS && s_q.status_armed))
    else $error("Overrun flag cleared without the status-then-data sequence.");
  chk_noise_with_avail: assert property (push && new_word.noise && fifo_empty |=>
    status_val[ST_NOISE] && status_val[ST_RX_AVAIL])
    else $error("Noise flag did not rise with available flag.");
  chk_framing_stop_zero: assert property (push && !bit_val |-> new_word.framing)
    else $error("Zero stop bit did not set framing flag.");
  chk_parity_when_enabled: assert property (push && !s_q.ctrl1[C1_PARITY_EN] |-> !new_word.parity)
    else $error("Parity error flagged while parity disabled.");
  chk_irq_low_pulse: assert property (!irq_n |=> irq_n)
    else $error("Interrupt request held low longer than one cycle.");
  chk_addr_qualify: assert property (push && s_q.ctrl2[C2_ADDR_EN] && !s_q.shift[8] |-> !rx_irq_evt)
    else $error("Data word raised interrupt in address mode.");
  chk_every_word_irq: assert property (push && s_q.ctrl2[C2_RX_IE] && !s_q.ctrl2[C2_ADDR_EN] |=> !irq_n)
    else $error("Received word raised no interrupt.");
  chk_wake_gated: assert property (wake_fire |-> global_irq_enable && uart_irq_enable &&
    s_q.recov_cnt == 8'd1)
    else $error("Wake interrupt fired early or without enables.");
  chk_recovery_discard: assert property (s_q.recov_cnt != 8'd0 |-> !push && s_d.phase == RX_IDLE)
    else $error("Line data received during wake recovery.");
  chk_stop_freeze: assert property (source_clock_stopped && s_q.recov_cnt == 8'd0 |=>
    $stable(s_q.phase) && $stable(s_q.shift))
    else $error("Receiver moved while source clock stopped.");
  chk_wake_edge: assert property (source_clock_stopped && wake_armed && s_q.rx_prev && !rx_pin |=>
    wake_req)
    else $error("Falling line edge did not request wake-up.");
  chk_stop_keeps_regs: assert property (stop_instruction && !(accept && bus_req.write) |=>
    $stable(s_q.ctrl1) && $stable(s_q.ctrl2) && $stable(s_q.baud))
    else $error("Registers changed during stop instruction.");

endmodule
`default_nettype wire

//--- dv/serial_tx_model.sv
// Behavioural remote serial transmitter that drives the receive line.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic sys_clk,
  output logic line
);
  //////////////////////////////////////////////////////////////////////////////
  // The line rests at the mark level between frames.
  initial begin
    line = 1'b1;
  end

  // One bit cell; a glitch flips one clock near mid-bit so only one vote of three disagrees.
  task automatic bit_out(input logic v, input logic g);
    for (int c = 0; c < BIT_CYC; c++) begin
      @(posedge sys_clk);
      line <= (g && c == 9) ? ~v : v;
    end
  endtask

  // A frame goes out least significant bit first, then parity if asked, then the stop bits.
  task automatic send(input logic [8:0] w, input int nb, input logic pen, input logic pbit,
                      input int nstop, input int bad, input logic gl);
    bit_out(1'b0, 1'b0);
    for (int i = 0; i < nb; i++) begin
      bit_out(w[i], gl && i == 0);
    end
    if (pen) begin
      bit_out(pbit, 1'b0);
    end
    for (int s = 1; s <= nstop; s++) begin
      bit_out(bad != s, 1'b0);
    end
    bit_out(1'b1, 1'b0);
  endtask

  // A bare falling edge, used to wake the port while its clock is stopped.
  task automatic hold_low(input int n);
    @(posedge sys_clk);
    line <= 1'b0;
    repeat (n) @(posedge sys_clk);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_uart_rx_error_irq_wake.sv
// Self-checking bench for the receive error, interrupt and wake-up block.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_rx_error_irq_wake;
  import uart_rx_pkg::*;
  localparam logic [7:0] SM = 8'hf4;
  logic sys_clk;
  logic sys_rst;
  avmm_req_t bus_req;
  avmm_rsp_t bus_rsp;
  wire logic rx_pin;
  logic tx_empty_flag;
  logic tx_idle_flag;
  logic source_clock_stopped;
  logic stop_instruction;
  logic global_irq_enable;
  logic uart_irq_enable;
  logic irq_n;
  logic wake_req;
  int n_errors;
  int cmp_count;
  int irq_cnt;
  int wake_cnt;
  int cyc;

  uart_rx_error_irq_wake dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .rx_pin(rx_pin), .tx_empty_flag(tx_empty_flag), .tx_idle_flag(tx_idle_flag),
    .source_clock_stopped(source_clock_stopped), .stop_instruction(stop_instruction),
    .global_irq_enable(global_irq_enable), .uart_irq_enable(uart_irq_enable), .irq_n(irq_n), .wake_req(wake_req));
  serial_tx_model #(.BIT_CYC(16)) u_tx (.sys_clk(sys_clk), .line(rx_pin));

  //////////////////////////////////////////////////////////////////////////////
  // Pulse counters and the hang guard; the run needs well under a third of the ceiling.
  always @(posedge sys_clk) begin
    cyc++;
    if (!sys_rst && irq_n === 1'b0) begin
      irq_cnt++;
    end
    if (!sys_rst && wake_req === 1'b1) begin
      wake_cnt++;
    end
    if (cyc == 30000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  // One Avalon transfer: held until waitrequest is sampled low, then released for a cycle.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
    bus_req.read <= !wr;
    bus_req.write <= wr;
    bus_req.address <= a;
    bus_req.writedata <= {24'h000000, wd};
    // Only the bench's cycle ceiling ends a wait that never finishes.
    do begin
      @(posedge sys_clk);
    end while (bus_rsp.waitrequest !== 1'b0);
    rd = bus_rsp.readdata[7:0];
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(x & m, e);
  endtask

  // Error flags are read before the word they belong to, which also arms the clear.
  task automatic take(input logic [7:0] st, input logic [7:0] d);
    expect_reg(STATUS_OFS, SM, st);
    expect_reg(DATA_OFS, 8'hff, d);
  endtask

  task automatic tx8(input logic [8:0] w);
    u_tx.send(w, 8, 1'b0, 1'b0, 1, 0, 1'b0);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    expect_reg(CTRL1_OFS, 8'hff, CTRL1_RST);
    expect_reg(CTRL2_OFS, 8'hff, CTRL2_RST);
    expect_reg(BAUD_OFS, 8'hff, BAUD_RST);
    expect_reg(8'h14, 8'hff, 8'h00);
    wr(STATUS_OFS, 8'hff);
    expect_reg(STATUS_OFS, SM, 8'h00);
  endtask

  task automatic t_basic();
    int b;
    wr(CTRL1_OFS, 8'h80);
    wr(CTRL2_OFS, 8'h88);
    b = irq_cnt;
    tx8(9'h05a);
    chk(8'(irq_cnt - b), 8'h01);
    take(8'h04, 8'h5a);
    expect_reg(STATUS_OFS, SM, 8'h00);
  endtask

  task automatic t_overrun();
    int b;
    b = irq_cnt;
    tx8(9'h011);
    tx8(9'h022);
    tx8(9'h033);
    chk(8'(irq_cnt - b), 8'h03);
    take(8'h24, 8'h11);
    take(8'h04, 8'h22);
    expect_reg(STATUS_OFS, SM, 8'h00);
  endtask

  task automatic t_noise();
    int b;
    b = irq_cnt;
    u_tx.send(9'h03c, 8, 1'b0, 1'b0, 1, 0, 1'b1);
    chk(8'(irq_cnt - b), 8'h01);
    take(8'h44, 8'h3c);
    expect_reg(STATUS_OFS, SM, 8'h00);
  endtask

  // A zero in either stop bit flags the word; a reset then wipes the flag.
  task automatic t_frame();
    for (int ns = 1; ns <= 2; ns++) begin
      for (int bad = 1; bad <= ns; bad++) begin
        wr(CTRL1_OFS, (ns == 2) ? 8'h88 : 8'h80);
        u_tx.send(9'h00f, 8, 1'b0, 1'b0, ns, bad, 1'b0);
        take(8'h14, 8'h0f);
      end
    end
    u_tx.send(9'h00f, 8, 1'b0, 1'b0, 2, 2, 1'b0);
    do_reset();
    expect_reg(STATUS_OFS, SM, 8'h00);
  endtask

  task automatic t_parity();
    logic p;
    wr(CTRL2_OFS, 8'h88);
    for (int odd = 0; odd < 2; odd++) begin
      wr(CTRL1_OFS, odd[0] ? 8'hb0 : 8'ha0);
      p = ^8'h35 ^ odd[0];
      u_tx.send(9'h035, 8, 1'b1, ~p, 1, 0, 1'b0);
      take(8'h84, 8'h35);
      u_tx.send(9'h035, 8, 1'b1, p, 1, 0, 1'b0);
      take(8'h04, 8'h35);
    end
  endtask

  // Parity stays off in address mode, as the two cannot share the top bit.
  task automatic t_addr();
    int b;
    for (int nine = 0; nine < 2; nine++) begin
      wr(CTRL1_OFS, nine[0] ? 8'hc0 : 8'h80);
      wr(CTRL2_OFS, 8'ha8);
      b = irq_cnt;
      u_tx.send(nine[0] ? 9'h100 : 9'h080, 8 + nine, 1'b0, 1'b0, 1, 0, 1'b0);
      u_tx.send(nine[0] ? 9'h0ff : 9'h07f, 8 + nine, 1'b0, 1'b0, 1, 0, 1'b0);
      chk(8'(irq_cnt - b), 8'h01);
      expect_reg(CTRL1_OFS, 8'h01, nine[0] ? 8'h01 : 8'h00);
      take(8'h04, nine[0] ? 8'h00 : 8'h80);
      take(8'h04, nine[0] ? 8'hff : 8'h7f);
    end
  endtask

  // Wake only while the clock is stopped; the interrupt waits out recovery and needs both system enables.
  task automatic t_wake();
    int b;
    int w;
    wr(CTRL1_OFS, 8'h80);
    wr(CTRL2_OFS, 8'h98);
    global_irq_enable <= 1'b1;
    uart_irq_enable <= 1'b1;
    source_clock_stopped <= 1'b1;
    b = irq_cnt;
    w = wake_cnt;
    u_tx.hold_low(20);
    repeat (5) @(posedge sys_clk);
    chk(8'(wake_cnt - w), 8'h01);
    source_clock_stopped <= 1'b0;
    repeat (90) @(posedge sys_clk);
    chk(8'(irq_cnt - b), 8'h00);
    repeat (20) @(posedge sys_clk);
    chk(8'(irq_cnt - b), 8'h01);
    global_irq_enable <= 1'b0;
    source_clock_stopped <= 1'b1;
    u_tx.hold_low(20);
    source_clock_stopped <= 1'b0;
    tx8(9'h0ff);
    chk(8'(wake_cnt - w), 8'h02);
    chk(8'(irq_cnt - b), 8'h01);
    expect_reg(STATUS_OFS, SM, 8'h00);
  endtask

  task automatic t_tx();
    int b;
    wr(CTRL2_OFS, 8'h06);
    b = irq_cnt;
    tx_empty_flag <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tx_idle_flag <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(8'(irq_cnt - b), 8'h02);
    expect_reg(STATUS_OFS, 8'h03, 8'h03);
    tx_empty_flag <= 1'b0;
    tx_idle_flag <= 1'b0;
    wr(CTRL2_OFS, 8'h88);
    tx_empty_flag <= 1'b1;
    tx_idle_flag <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(8'(irq_cnt - b), 8'h02);
    wr(BAUD_OFS, 8'h05);
    stop_instruction <= 1'b1;
    repeat (4) @(posedge sys_clk);
    stop_instruction <= 1'b0;
    expect_reg(CTRL2_OFS, 8'hff, 8'h88);
    expect_reg(BAUD_OFS, 8'hff, 8'h05);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock, reset and the main sequence.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    n_errors = 0;
    cmp_count = 0;
    irq_cnt = 0;
    wake_cnt = 0;
    cyc = 0;
    sys_rst = 1'b1;
    bus_req = '0;
    tx_empty_flag = 1'b0;
    tx_idle_flag = 1'b0;
    source_clock_stopped = 1'b0;
    stop_instruction = 1'b0;
    global_irq_enable = 1'b0;
    uart_irq_enable = 1'b0;
    do_reset();
    t_regs();
    t_basic();
    t_overrun();
    t_noise();
    t_frame();
    t_parity();
    t_addr();
    t_wake();
    t_tx();
    wrap_up();
  end
endmodule
`default_nettype wire
